// >>> sfep_pkg.sv
`default_nettype none

package sfep_pkg;

  // Command opcodes
  localparam logic [7:0] OPC_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OPC_SMALL_WIPE = 8'h20;
  localparam logic [7:0] OPC_LARGE_WIPE = 8'hD8;
  localparam logic [7:0] OPC_ARRAY_WIPE = 8'h60;
  localparam logic [7:0] OPC_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OPC_QUAD_PAGE_WRITE = 8'h38;

  // Frame byte counts: opcode, then three address bytes, then data
  localparam logic [3:0] BYTES_OPCODE_ONLY = 4'h1;
  localparam logic [3:0] BYTES_ADDR_LAST = 4'h3;
  localparam logic [3:0] BYTES_WITH_ADDR = 4'h4;
  localparam logic [3:0] BYTES_WITH_DATA = 4'h5;
  localparam logic [3:0] BYTES_SAT = 4'hF;

  // Protection: 64 blocks of 64K, upper blocks protected first
  localparam logic [6:0] PROT_BLOCKS = 7'h40;
  localparam logic [3:0] PROT_LEVEL_ALL = 4'h7;
  localparam logic [3:0] PROT_LEVEL_NONE = 4'h0;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned ARR_WORD_W = 34;

  // Self-timed cycle lengths
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SMALL_WIPE_TIME_US = 100;
  localparam int unsigned LARGE_WIPE_TIME_US = 1000;
  localparam int unsigned ARRAY_WIPE_TIME_US = 10000;
  localparam int unsigned PAGE_WRITE_TIME_US = 50;
  localparam int unsigned SMALL_WIPE_CYC = SMALL_WIPE_TIME_US * CLK_MHZ;
  localparam int unsigned LARGE_WIPE_CYC = LARGE_WIPE_TIME_US * CLK_MHZ;
  localparam int unsigned ARRAY_WIPE_CYC = ARRAY_WIPE_TIME_US * CLK_MHZ;
  localparam int unsigned PAGE_WRITE_CYC = PAGE_WRITE_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ARR_SMALL = 2'b00,
    ARR_LARGE = 2'b01,
    ARR_ALL = 2'b10,
    ARR_PROG = 2'b11
  } sfep_arr_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } sfep_state_t;

endpackage

`default_nettype wire

// >>> sfep_stream_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sfep_stream_if #(parameter int unsigned WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

`default_nettype wire

// >>> sfep_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// DEPTH must be a power of two
module sfep_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Async reset, active low
  sfep_stream_if.snk inPort, // Filling side
  sfep_stream_if.src outPort // Draining side
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } sfep_fifo_st_t;

  sfep_fifo_st_t state_q;
  sfep_fifo_st_t state_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign inPort.ready = state_q.cnt != (AW+1)'(DEPTH);
  assign outPort.valid = state_q.cnt != '0;
  assign outPort.data = mem[state_q.rd];
  assign push = inPort.valid && inPort.ready;
  assign pop = outPort.valid && outPort.ready;

  always_comb begin
    state_d = state_q;
    if (push) begin
      state_d.wr = AW'(state_q.wr + 1'b1);
    end
    if (pop) begin
      state_d.rd = AW'(state_q.rd + 1'b1);
    end
    state_d.cnt = (AW+1)'(state_q.cnt + push - pop);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[state_q.wr] <= inPort.data;
    end
  end
endmodule

`default_nettype wire

// >>> sfep_flash_seq.sv
// Summary of operation
// R1 - Small wipe sets 4K sector to ones
// R2 - Host sends unlock before erase or write
// R3 - Sector chosen by address bits A12 upward
// R4 - Erase needs select release on byte boundary
// R5 - Small wipe: opcode then three address bytes
// R6 - Busy during cycle; end clears busy, latch
// R7 - No small wipe on protected area
// R8 - Large wipe sets containing 64K block ones
// R9 - Large wipe: opcode then three address bytes
// R10 - No large wipe on protected block
// R11 - Array wipe: opcode only, no address
// R12 - Array wipe only with protect level zero
// R13 - Page write only clears bits to zero
// R14 - Beyond 256 bytes keep last 256
// R15 - Low address byte wraps within page
// R16 - Short write leaves other page bytes
// R17 - Page write: opcode, address, data bytes
// R18 - Page write released after full byte
// R19 - No page write on protected page
// R20 - Quad write needs unlock and lane enable
// R21 - Quad write address, data on four lanes
// R22 - Host may slow clock for quad data
// R23 - Commands refused while cycle is running
// R24 - Without unlock latch, command is ignored
// R25 - Rejected command leaves busy low
`timescale 1ns/1ps
`default_nettype none

module sfep_flash_seq #(
  parameter int unsigned SMALL_WIPE_CYC = sfep_pkg::SMALL_WIPE_CYC,
  parameter int unsigned LARGE_WIPE_CYC = sfep_pkg::LARGE_WIPE_CYC,
  parameter int unsigned ARRAY_WIPE_CYC = sfep_pkg::ARRAY_WIPE_CYC,
  parameter int unsigned PAGE_WRITE_CYC = sfep_pkg::PAGE_WRITE_CYC
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic serialClk, // Host serial clock pin
  input wire logic chipSelectN, // Host select pin, active low
  input wire logic [3:0] ioLaneIn, // Data lanes in, lane 0 is serial in
  output logic [3:0] ioLaneOut, // Data lanes out
  output logic [3:0] ioLaneOeN, // Lane drive enable, active low
  input wire logic [3:0] protectLevelBits, // Protection level
  input wire logic fourLaneEnable, // Allows quad page write
  output logic busyFlag, // Internal cycle running
  output logic writeUnlockLatch, // Write unlock latch
  output logic arrValid, // Array operation valid
  input wire logic arrReady, // Array accepts operation
  output logic [1:0] arrOp, // Array operation kind
  output logic [23:0] arrAddr, // Array byte address
  output logic [7:0] arrData // Array data, ones for erase
);

  typedef struct packed {
    logic [2:0] sclkSync;
    logic [2:0] csSync;
    logic [3:0] io1;
    logic [3:0] io2;
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic [3:0] byteCnt;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] col;
    logic quad;
    logic write_unlock_latch;
    logic [255:0] mask;
    sfep_pkg::sfep_state_t st;
    logic [31:0] timer;
    logic [8:0] scan;
    sfep_pkg::sfep_arr_op_t op;
    logic [23:0] opAddr;
    logic pushPend;
  } sfep_seq_st_t;

  sfep_seq_st_t state_q;
  sfep_seq_st_t state_d;
  logic [7:0] pageMem [sfep_pkg::PAGE_BYTES];

  logic sclkRise;
  logic csLow;
  logic csFall;
  logic csRise;
  logic busy;
  logic [3:0] bitNext;
  logic [7:0] newByte;
  logic byteDone;
  logic capture;
  logic [7:0] scanIdx;
  logic scanHit;
  logic welSet;
  logic startOk;
  sfep_pkg::sfep_arr_op_t startOp;
  logic [23:0] startAddr;
  logic [31:0] startCyc;

  sfep_stream_if #(.WIDTH(sfep_pkg::ARR_WORD_W)) pushIf ();
  sfep_stream_if #(.WIDTH(sfep_pkg::ARR_WORD_W)) popIf ();

  // Upper blocks are protected first; level 7 and above covers all
  function automatic logic isProt(input logic [3:0] lvl, input logic [23:0] a);
    logic [6:0] span;
    begin
      if (lvl == sfep_pkg::PROT_LEVEL_NONE) begin
        span = 7'h00;
      end else if (lvl >= sfep_pkg::PROT_LEVEL_ALL) begin
        span = sfep_pkg::PROT_BLOCKS;
      end else begin
        span = 7'(7'h01 << (lvl - 4'h1));
      end
      return (7'(a[21:16]) + span) >= sfep_pkg::PROT_BLOCKS;
    end
  endfunction

  function automatic logic isPageCmd(input logic [7:0] c);
    return c == sfep_pkg::OPC_PAGE_WRITE || c == sfep_pkg::OPC_QUAD_PAGE_WRITE;
  endfunction

  // Edges seen after the second sync stage only
  assign sclkRise = state_q.sclkSync[1] && !state_q.sclkSync[2];
  assign csLow = !state_q.csSync[1];
  assign csFall = !state_q.csSync[1] && state_q.csSync[2];
  assign csRise = state_q.csSync[1] && !state_q.csSync[2];
  assign busy = state_q.st == sfep_pkg::ST_RUN;
  assign bitNext = {1'b0, state_q.bitCnt} + (state_q.quad ? 4'h4 : 4'h1); // R21
  assign newByte = state_q.quad ? {state_q.shift[3:0], state_q.io2}
                                 : {state_q.shift[6:0], state_q.io2[0]};
  assign byteDone = sclkRise && csLow && bitNext[3];
  // Data bytes of a page write are only kept while idle
  assign capture = byteDone && !busy && isPageCmd(state_q.cmd) // R23
                   && state_q.byteCnt >= sfep_pkg::BYTES_WITH_ADDR;
  assign scanIdx = state_q.scan[7:0];
  assign scanHit = !state_q.scan[8] && state_q.mask[scanIdx]; // R16

  // Lanes are input only here; status leaves on busyFlag
  assign ioLaneOut = 4'h0;
  assign ioLaneOeN = 4'hF;
  assign busyFlag = busy; // R6
  assign writeUnlockLatch = state_q.write_unlock_latch;

  assign pushIf.valid = busy && (state_q.pushPend || scanHit);
  assign pushIf.data = state_q.pushPend
      ? {state_q.op, state_q.opAddr, sfep_pkg::ERASED_BYTE} // R1 R8
      : {sfep_pkg::ARR_PROG, state_q.opAddr[23:8], scanIdx, pageMem[scanIdx]}; // R13
  assign popIf.ready = arrReady;
  assign arrValid = popIf.valid;
  assign arrOp = popIf.data[33:32];
  assign arrAddr = popIf.data[31:8];
  assign arrData = popIf.data[7:0];

  sfep_fifo #(
    .WIDTH(sfep_pkg::ARR_WORD_W),
    .DEPTH(sfep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .inPort(pushIf),
    .outPort(popIf)
  );

  // Decision taken at select release
  always_comb begin
    welSet = 1'b0;
    startOk = 1'b0;
    startOp = sfep_pkg::ARR_PROG;
    startAddr = state_q.addr;
    startCyc = PAGE_WRITE_CYC;
    if (csRise && !busy && state_q.bitCnt == 3'h0) begin // R4 R18 R23 R25
      case (state_q.cmd)
        sfep_pkg::OPC_WRITE_UNLOCK: begin
          welSet = state_q.byteCnt == sfep_pkg::BYTES_OPCODE_ONLY;
        end
        sfep_pkg::OPC_SMALL_WIPE: begin
          startOk = state_q.byteCnt == sfep_pkg::BYTES_WITH_ADDR && state_q.write_unlock_latch // R2 R24
                    && !isProt(protectLevelBits, state_q.addr); // R7
          startOp = sfep_pkg::ARR_SMALL;
          startAddr = {state_q.addr[23:12], 12'h000}; // R1 R3
          startCyc = SMALL_WIPE_CYC;
        end
        sfep_pkg::OPC_LARGE_WIPE: begin
          startOk = state_q.byteCnt == sfep_pkg::BYTES_WITH_ADDR && state_q.write_unlock_latch // R24
                    && !isProt(protectLevelBits, state_q.addr); // R10
          startOp = sfep_pkg::ARR_LARGE;
          startAddr = {state_q.addr[23:16], 16'h0000}; // R8
          startCyc = LARGE_WIPE_CYC;
        end
        sfep_pkg::OPC_ARRAY_WIPE: begin
          startOk = state_q.byteCnt == sfep_pkg::BYTES_OPCODE_ONLY && state_q.write_unlock_latch // R24
                    && protectLevelBits == sfep_pkg::PROT_LEVEL_NONE; // R12
          startOp = sfep_pkg::ARR_ALL;
          startAddr = 24'h00_0000;
          startCyc = ARRAY_WIPE_CYC;
        end
        sfep_pkg::OPC_PAGE_WRITE, sfep_pkg::OPC_QUAD_PAGE_WRITE: begin
          startOk = state_q.byteCnt >= sfep_pkg::BYTES_WITH_DATA && state_q.write_unlock_latch // R24
                    && !isProt(protectLevelBits, state_q.addr) // R19
                    && (state_q.cmd == sfep_pkg::OPC_PAGE_WRITE || state_q.quad); // R20
        end
        default: begin
          startOk = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    state_d.sclkSync = {state_q.sclkSync[1:0], serialClk};
    state_d.csSync = {state_q.csSync[1:0], chipSelectN};
    state_d.io1 = ioLaneIn;
    state_d.io2 = state_q.io1;
    if (csFall) begin
      state_d.bitCnt = 3'h0;
      state_d.byteCnt = 4'h0;
      state_d.quad = 1'b0;
      // Mask still feeds the running program scan
      if (!busy) begin
        state_d.mask = '0;
      end
    end else if (sclkRise && csLow) begin
      state_d.shift = newByte;
      state_d.bitCnt = bitNext[2:0];
      if (bitNext[3]) begin
        if (state_q.byteCnt == 4'h0) begin
          state_d.cmd = newByte;
          state_d.quad = newByte == sfep_pkg::OPC_QUAD_PAGE_WRITE && fourLaneEnable; // R20 R21
        end else if (state_q.byteCnt <= sfep_pkg::BYTES_ADDR_LAST) begin
          state_d.addr = {state_q.addr[15:0], newByte};
          state_d.col = newByte;
        end
        if (capture) begin
          // Column wrap overwrites the oldest bytes of the page
          state_d.mask[state_q.col] = 1'b1; // R14 R16
          state_d.col = state_q.col + 8'h01; // R15
        end
        if (state_q.byteCnt != sfep_pkg::BYTES_SAT) begin
          state_d.byteCnt = state_q.byteCnt + 4'h1;
        end
      end
    end
    case (state_q.st)
      sfep_pkg::ST_IDLE: begin
        if (welSet) begin
          state_d.write_unlock_latch = 1'b1;
        end
        if (startOk) begin
          state_d.st = sfep_pkg::ST_RUN; // R6
          state_d.op = startOp;
          state_d.opAddr = startAddr;
          state_d.timer = startCyc;
          state_d.pushPend = startOp != sfep_pkg::ARR_PROG;
          state_d.scan = (startOp == sfep_pkg::ARR_PROG) ? 9'h000 : 9'h100;
        end
      end
      sfep_pkg::ST_RUN: begin
        if (state_q.timer != 32'h0000_0000) begin
          state_d.timer = state_q.timer - 32'h0000_0001;
        end
        // A stalled array keeps the cycle busy past its nominal time
        if (state_q.pushPend) begin
          if (pushIf.ready) begin
            state_d.pushPend = 1'b0;
          end
        end else if (!state_q.scan[8] && (!scanHit || pushIf.ready)) begin
          state_d.scan = state_q.scan + 9'h001;
        end
        if (state_q.timer == 32'h0000_0000 && !state_q.pushPend && state_q.scan[8]) begin
          state_d.st = sfep_pkg::ST_IDLE; // R6
          state_d.write_unlock_latch = 1'b0; // R6
        end
      end
      default: begin
        state_d.st = sfep_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (capture) begin
      pageMem[state_q.col] <= newByte; // R15
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_start_needs_wel: assert property (startOk |-> state_q.write_unlock_latch) // R24
    else $error("cycle started without unlock latch");
  chk_end_clears_wel: assert property ($fell(busyFlag) |-> !writeUnlockLatch) // R6
    else $error("unlock latch still set after cycle end");
  chk_start_busy_len: assert property (startOk |=> busyFlag && state_q.timer == $past(startCyc)) // R6
    else $error("busy or timer wrong after start");
  chk_boundary_only: assert property (startOk |-> csRise && state_q.bitCnt == 3'h0) // R4 R18
    else $error("cycle started off a byte boundary");
  chk_protect_skip: assert property (startOk && startOp != sfep_pkg::ARR_ALL // R7 R10 R19
      |-> !isProt(protectLevelBits, state_q.addr))
    else $error("cycle started on protected area");
  chk_array_level: assert property (startOk && startOp == sfep_pkg::ARR_ALL // R12
      |-> protectLevelBits == sfep_pkg::PROT_LEVEL_NONE)
    else $error("array wipe with nonzero protect level");
  chk_erase_word: assert property (pushIf.valid && state_q.pushPend // R1 R3 R8
      |-> pushIf.data[7:0] == 8'hFF && (state_q.op == sfep_pkg::ARR_LARGE
          ? pushIf.data[23:8] == 16'h0000 : pushIf.data[19:8] == 12'h000))
    else $error("erase word not aligned or not ones");
  chk_col_wrap: assert property (capture |=> state_q.col == $past(state_q.col) + 8'h01) // R15
    else $error("page column did not step");
  chk_busy_no_capture: assert property (busyFlag |-> !capture && !welSet) // R23
    else $error("command taken while busy");
  chk_prog_masked: assert property (pushIf.valid && !state_q.pushPend // R13 R16
      |-> state_q.mask[scanIdx] && pushIf.data[33:32] == sfep_pkg::ARR_PROG)
    else $error("program word for unwritten column");
  chk_reject_idle: assert property (csRise && !busy && state_q.bitCnt != 3'h0 // R25
      |=> !busyFlag)
    else $error("misaligned release started a cycle");

  // Cycle may not end early or with words still unissued
  chk_busy_holds: assert property (busyFlag && state_q.timer != 32'h0000_0000 |=> busyFlag) // R6
    else $error("busy dropped before cycle time");
  chk_end_drained: assert property ($fell(busyFlag) // R6
      |-> $past(state_q.scan[8]) && !$past(state_q.pushPend))
    else $error("cycle ended with words unissued");
  chk_quad_lanes: assert property (startOk && state_q.cmd == sfep_pkg::OPC_QUAD_PAGE_WRITE // R21
      |-> state_q.quad)
    else $error("quad write started without four lanes");
  chk_idle_no_word: assert property (!busyFlag |-> !pushIf.valid) // R25
    else $error("array word issued while idle");

  cov_small_wipe: cover property (startOk && startOp == sfep_pkg::ARR_SMALL);
  cov_array_wipe: cover property (startOk && startOp == sfep_pkg::ARR_ALL);
  cov_large_wipe: cover property (startOk && startOp == sfep_pkg::ARR_LARGE);
  cov_quad_write: cover property (startOk && state_q.quad);
  cov_page_wrap: cover property (capture && state_q.col == 8'hFF);

endmodule

`default_nettype wire

// >>> sfep_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the link; serial clock idles low and only runs inside frames
module sfep_host_model (
  input wire logic sys_clk, // Pacing clock
  output logic serialClk, // Serial clock to device
  output logic chipSelectN, // Select, active low
  output logic [3:0] ioLaneIn // Lanes toward device
);
  initial begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    ioLaneIn = 4'h5;
  end

  // Four system clocks a phase: 80 ns period, well under the quad speed limit
  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic open_frame();
    @(negedge sys_clk);
    chipSelectN = 1'b0;
    half();
  endtask

  // Clocks nClk edges; serial MSB first on lane 0, quad sends high nibble first
  task automatic shift(input logic [7:0] val, input int nClk, input bit quad);
    int k;
    for (k = 0; k < nClk; k++) begin
      if (quad) begin
        ioLaneIn = (k == 0) ? val[7:4] : val[3:0];
      end else begin
        ioLaneIn = {~ioLaneIn[3:1], val[7-k]};
      end
      half();
      serialClk = 1'b1;
      half();
      serialClk = 1'b0;
    end
  endtask

  // Released lanes show a changing pattern, not the last bit
  task automatic close_frame();
    half();
    chipSelectN = 1'b1;
    ioLaneIn = ~ioLaneIn;
    repeat (8) @(negedge sys_clk);
  endtask
endmodule

`default_nettype wire

// >>> serial_flash_erase_program_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end

module serial_flash_erase_program_test;
  localparam int unsigned CYC = 20;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic serialClk, chipSelectN, busyFlag, writeUnlockLatch, arrValid;
  logic [3:0] ioLaneIn, ioLaneOut, ioLaneOeN;
  logic [3:0] protectLevelBits = 4'h0;
  logic fourLaneEnable = 1'b0;
  logic arrReady = 1'b0;
  logic stall = 1'b0;
  logic [1:0] arrOp;
  logic [23:0] arrAddr;
  logic [7:0] arrData;
  logic [33:0] expQ[$];
  logic [33:0] expW;
  logic [7:0] pay[$];
  int bad_count = 0;
  int comparisons = 0;
  int seed = 38;
  int rnd, lvl, blk, i;

  sfep_flash_seq #(.SMALL_WIPE_CYC(CYC), .LARGE_WIPE_CYC(CYC), .ARRAY_WIPE_CYC(CYC),
    .PAGE_WRITE_CYC(CYC)) DUT (.sys_clk(sys_clk), .nrst(nrst), .serialClk(serialClk),
    .chipSelectN(chipSelectN), .ioLaneIn(ioLaneIn), .ioLaneOut(ioLaneOut), .ioLaneOeN(ioLaneOeN),
    .protectLevelBits(protectLevelBits), .fourLaneEnable(fourLaneEnable),
    .busyFlag(busyFlag), .writeUnlockLatch(writeUnlockLatch), .arrValid(arrValid),
    .arrReady(arrReady), .arrOp(arrOp), .arrAddr(arrAddr), .arrData(arrData));

  sfep_host_model host (.sys_clk(sys_clk), .serialClk(serialClk),
    .chipSelectN(chipSelectN), .ioLaneIn(ioLaneIn));

  always #5 sys_clk = ~sys_clk;

  // Random back-pressure from the array; stall holds it off to fill the FIFO
  always @(negedge sys_clk) begin
    rnd = $random(seed);
    arrReady <= ~stall & rnd[0];
  end

  always @(posedge sys_clk) begin
    if (nrst && arrValid === 1'b1 && arrReady === 1'b1) begin
      expW = (expQ.size() > 0) ? expQ.pop_front() : 'x;
      `CHK("array word", expW, {arrOp, arrAddr, arrData})
    end
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] opc, input logic [23:0] addr, input bit withAddr,
      input bit quad, input int tail);
    int k;
    host.open_frame();
    host.shift(opc, 8, 1'b0);
    if (withAddr) begin
      for (k = 2; k >= 0; k--) host.shift(addr[8*k+:8], quad ? 2 : 8, quad);
    end
    foreach (pay[j]) host.shift(pay[j], quad ? 2 : 8, quad);
    if (tail > 0) begin
      host.shift(8'hA5, tail, 1'b0);
    end
    host.close_frame();
  endtask

  task automatic unlock();
    pay = {};
    send(sfep_pkg::OPC_WRITE_UNLOCK, 24'h00_0000, 1'b0, 1'b0, 0);
    `CHK("latch set", 1'b1, writeUnlockLatch)
  endtask

  task automatic finish_run();
    int n;
    `CHK("busy running", 1'b1, busyFlag)
    n = 0;
    // Words may still sit in the buffer after busy drops
    while ((busyFlag === 1'b1 || arrValid === 1'b1) && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("busy cleared", 1'b0, busyFlag)
    `CHK("latch cleared", 1'b0, writeUnlockLatch)
    `CHK("words left", 0, expQ.size())
  endtask

  initial begin
    #900_000;
    bad_count++;
    test_done();
  end

  initial begin
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (6) @(negedge sys_clk);
    pay = {8'h12};
    send(sfep_pkg::OPC_PAGE_WRITE, 24'h00_0100, 1'b1, 1'b0, 0);
    `CHK("no latch busy", 1'b0, busyFlag)
    unlock();
    send(sfep_pkg::OPC_SMALL_WIPE, 24'h01_2345, 1'b1, 1'b0, 3);
    `CHK("odd release busy", 1'b0, busyFlag)
    `CHK("latch kept", 1'b1, writeUnlockLatch)
    pay = {8'h34};
    send(sfep_pkg::OPC_PAGE_WRITE, 24'h00_0100, 1'b1, 1'b0, 4);
    `CHK("partial data busy", 1'b0, busyFlag)
    pay = {};
    expQ.push_back({sfep_pkg::ARR_SMALL, 24'h01_2000, 8'hFF});
    send(sfep_pkg::OPC_SMALL_WIPE, 24'h01_2345, 1'b1, 1'b0, 0);
    finish_run();
    // Each level: lowest protected block refused; below level 7, highest free block accepted
    for (lvl = 1; lvl <= 7; lvl++) begin
      protectLevelBits = lvl[3:0];
      blk = 64 - (1 << (lvl - 1));
      unlock();
      pay = {};
      send(sfep_pkg::OPC_LARGE_WIPE, {2'b00, blk[5:0], 16'h8001}, 1'b1, 1'b0, 0);
      `CHK("protected block busy", 1'b0, busyFlag)
      send(sfep_pkg::OPC_ARRAY_WIPE, 24'h00_0000, 1'b0, 1'b0, 0);
      `CHK("protected array busy", 1'b0, busyFlag)
      send(sfep_pkg::OPC_SMALL_WIPE, {2'b00, blk[5:0], 16'hF123}, 1'b1, 1'b0, 0);
      `CHK("protected sector busy", 1'b0, busyFlag)
      pay = {8'h55};
      send(sfep_pkg::OPC_PAGE_WRITE, {2'b00, blk[5:0], 16'h0010}, 1'b1, 1'b0, 0);
      `CHK("protected page busy", 1'b0, busyFlag)
      if (lvl < 7) begin
        blk = blk - 1;
        pay = {};
        expQ.push_back({sfep_pkg::ARR_LARGE, 2'b00, blk[5:0], 16'h0000, 8'hFF});
        send(sfep_pkg::OPC_LARGE_WIPE, {2'b00, blk[5:0], 16'hFFFF}, 1'b1, 1'b0, 0);
        finish_run();
      end
    end
    protectLevelBits = 4'h0;
    unlock();
    expQ.push_back({sfep_pkg::ARR_ALL, 24'h00_0000, 8'hFF});
    send(sfep_pkg::OPC_ARRAY_WIPE, 24'h00_0000, 1'b0, 1'b0, 0);
    finish_run();
    // Wrap past the page end; untouched columns produce no words
    unlock();
    pay = {8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
    expQ.push_back({sfep_pkg::ARR_PROG, 24'h00_0100, pay[2]});
    expQ.push_back({sfep_pkg::ARR_PROG, 24'h00_01FE, pay[0]});
    expQ.push_back({sfep_pkg::ARR_PROG, 24'h00_01FF, pay[1]});
    send(sfep_pkg::OPC_PAGE_WRITE, 24'h00_01FE, 1'b1, 1'b0, 0);
    finish_run();
    // Long write with the array stalled; a frame while busy must change nothing
    unlock();
    pay = {};
    for (i = 0; i < 258; i++) pay.push_back(8'($random(seed)));
    for (i = 0; i < 256; i++) begin
      expQ.push_back({sfep_pkg::ARR_PROG, 16'h0002, i[7:0], pay[i < 2 ? 256 + i : i]});
    end
    stall = 1'b1;
    send(sfep_pkg::OPC_PAGE_WRITE, 24'h00_0200, 1'b1, 1'b0, 0);
    pay = {};
    send(sfep_pkg::OPC_SMALL_WIPE, 24'h00_5000, 1'b1, 1'b0, 0);
    `CHK("full buffer offers word", 1'b1, arrValid)
    `CHK("busy while stalled", 1'b1, busyFlag)
    stall = 1'b0;
    finish_run();
    unlock();
    pay = {8'($random(seed))};
    send(sfep_pkg::OPC_QUAD_PAGE_WRITE, 24'h00_0310, 1'b1, 1'b1, 0);
    `CHK("quad disabled busy", 1'b0, busyFlag)
    fourLaneEnable = 1'b1;
    expQ.push_back({sfep_pkg::ARR_PROG, 24'h00_0310, pay[0]});
    send(sfep_pkg::OPC_QUAD_PAGE_WRITE, 24'h00_0310, 1'b1, 1'b1, 0);
    finish_run();
    `CHK("lanes undriven", 4'hF, ioLaneOeN)
    `CHK("lane data idle", 4'h0, ioLaneOut)
    test_done();
  end
endmodule

`default_nettype wire
